// file: logic/stbrc_pkg.sv
// Constants and types shared by the standby release controller
package stbrc_pkg;
  // Wake latency in CPU clocks: first figure, slower path adds one
  localparam int unsigned WAKE_SVC_CYC = 8;
  localparam int unsigned WAKE_RES_CYC = 2;
  localparam int unsigned OSC_STABILIZATION_SELECT_W = 3;
  localparam logic [2:0] OSC_STABILIZATION_SELECT_RST = 3'h5;
  // Wide timer clock selects
  localparam logic [1:0] WSEL_C2OUT = 2'h2;
  localparam logic [1:0] WSEL_PIN = 2'h3;
  // 8-bit counter clock select for its own pin
  localparam logic [1:0] CSEL_PIN = 2'h3;
  localparam logic [1:0] HSEL_C0OUT = 2'h3;
  // Register offsets
  localparam logic [3:0] REG_OSC_STABILIZATION_SELECT = 4'h0;
  localparam logic [3:0] REG_TSEL = 4'h1;
  localparam logic [3:0] REG_STAT = 4'h2;
  localparam logic [3:0] REG_CNT = 4'h3;
  localparam int unsigned TSEL_WIDE_POS = 0;
  localparam int unsigned TSEL_C0_POS = 2;
  localparam int unsigned TSEL_C1_POS = 4;
  localparam int unsigned TSEL_C2_POS = 6;
  localparam int unsigned TSEL_H0_POS = 8;
  localparam logic [9:0] TSEL_RST = 10'h000;
  typedef enum logic [2:0]
  {
    ST_RUN = 3'b000,
    ST_HALT = 3'b001,
    ST_STOP = 3'b010,
    ST_STAB = 3'b011,
    ST_WAKE = 3'b100
  } stbrc_state_e;
endpackage

// file: logic/stbrc_if.sv
`timescale 1ns/1ps
// Latency counter handshake between controller and counter module
interface stbrc_cnt_if;
  logic load;
  logic [15:0] value;
  logic tick;
  logic done;
  modport ctrl(output load, output value, output tick, input done);
  modport cnt(input load, input value, input tick, output done);
endinterface

// file: logic/stbrc_wait_cnt.sv
`timescale 1ns/1ps
// Down counter for wake latency and stabilization waits
module stbrc_wait_cnt (
  input wire logic mclk,
  input wire logic sys_rst,
  stbrc_cnt_if.cnt cif
);
  logic [15:0] cnt_q;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      cnt_q <= 16'h0000;
    else if (cif.load)
      cnt_q <= cif.value;
    else if (cif.tick && cnt_q != 16'h0000)
      cnt_q <= cnt_q - 16'h0001;
  end
  // Done only after a count actually ran down, so a fresh load never reads as done
  assign cif.done = (cnt_q == 16'h0001) && cif.tick && !cif.load;
endmodule

// file: logic/stbrc_top.sv
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Standby release controller: halt/stop entry, wake decode, latency and stop-mode timer gating
module stbrc_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cpu_clk_en,
  input wire logic cpu_on_main_clk,
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic irq_req,
  input wire logic irq_mask_flag,
  input wire logic irq_priority_flag,
  input wire logic global_irq_accept,
  input wire logic in_service_priority_state,
  input wire logic counter_zero_running,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic cpu_clk_gate,
  output logic in_halt,
  output logic in_stop,
  output logic wake_service,
  output logic wake_resume,
  output logic reset_vector_req,
  output logic wide_timer_run,
  output logic counter_zero_run,
  output logic counter_one_run,
  output logic counter_two_run,
  output logic interval_timer_zero_run
);
  stbrc_pkg::stbrc_state_e state_q;
  stbrc_pkg::stbrc_state_e state_d;
  logic [2:0] osc_stabilization_select_q;
  logic [9:0] tsel_q;
  logic svc_q;
  logic halt_seen_q;
  logic [15:0] lat_cnt_q;
  logic wake_req;
  logic svc_now;
  stbrc_cnt_if cif ();

  stbrc_wait_cnt u_cnt (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .cif(cif)
  );

  // Stabilization wait grows as 2^(10+sel) CPU clocks for sel 0 to 5; sel 6 and 7 overflow the 16-bit value to zero
  function automatic logic [15:0] stab_cycles(input logic [2:0] sel);
    stab_cycles = 16'h0400 << sel;
  endfunction

  assign wake_req = irq_req && !irq_mask_flag;
  // Priority 0 needs only global accept; priority 1 also needs in-service state
  assign svc_now = global_irq_accept && (!irq_priority_flag || in_service_priority_state);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      stbrc_pkg::ST_RUN:
      begin
        if (stop_exec && cpu_on_main_clk)
          state_d = wake_req ? stbrc_pkg::ST_STAB : stbrc_pkg::ST_STOP;
        else if (halt_exec)
          state_d = stbrc_pkg::ST_HALT;
      end
      stbrc_pkg::ST_HALT:
        if (wake_req)
          state_d = stbrc_pkg::ST_WAKE;
      stbrc_pkg::ST_STOP:
        if (wake_req)
          state_d = stbrc_pkg::ST_STAB;
      stbrc_pkg::ST_STAB:
        if (cif.done)
          state_d = stbrc_pkg::ST_RUN;
      stbrc_pkg::ST_WAKE:
        if (cif.done)
          state_d = stbrc_pkg::ST_RUN;
      default:
        state_d = stbrc_pkg::ST_RUN;
    endcase
  end

  // Reset wins over every standby state
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      state_q <= stbrc_pkg::ST_RUN;
    else
      state_q <= state_d;
  end

  // Service decision latched at the wake request, so later flag changes do not alter it
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      svc_q <= 1'b0;
    else if (state_q == stbrc_pkg::ST_HALT && wake_req)
      svc_q <= svc_now;
  end

  always_comb
  begin
    cif.load = 1'b0;
    cif.value = 16'h0000;
    if (state_q == stbrc_pkg::ST_HALT && wake_req)
    begin
      cif.load = 1'b1;
      // Request cycle counts only if the CPU clock ticks in it; otherwise one more tick gives the 9 or 3 figure
      cif.value = (svc_now ? 16'(stbrc_pkg::WAKE_SVC_CYC - 1) : 16'(stbrc_pkg::WAKE_RES_CYC - 1)) +
                  {15'h0000, !cpu_clk_en};
    end
    else if (state_d == stbrc_pkg::ST_STAB && state_q != stbrc_pkg::ST_STAB)
    begin
      cif.load = 1'b1;
      cif.value = stab_cycles(osc_stabilization_select_q);
    end
  end
  // Counted in the pre-standby CPU clock enable, which keeps running in halt
  assign cif.tick = cpu_clk_en;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      halt_seen_q <= 1'b0;
    else
      halt_seen_q <= (state_q == stbrc_pkg::ST_HALT);
  end

  // Outputs from flip-flops
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wake_service <= 1'b0;
      wake_resume <= 1'b0;
    end
    else
    begin
      wake_service <= state_q == stbrc_pkg::ST_WAKE && cif.done && svc_q;
      wake_resume <= state_q == stbrc_pkg::ST_WAKE && cif.done && !svc_q;
    end
  end

  // Reset-vector request flags every reset, whether or not it ended a standby state
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      reset_vector_req <= 1'b1;
    else
      reset_vector_req <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      in_halt <= 1'b0;
      in_stop <= 1'b0;
      cpu_clk_gate <= 1'b1;
    end
    else
    begin
      in_halt <= state_d == stbrc_pkg::ST_HALT || state_d == stbrc_pkg::ST_WAKE;
      in_stop <= state_d == stbrc_pkg::ST_STOP;
      // CPU clock cut in halt, wake, stop and through the stabilization wait
      cpu_clk_gate <= !(state_d == stbrc_pkg::ST_STOP || state_d == stbrc_pkg::ST_STAB ||
                        state_d == stbrc_pkg::ST_HALT || state_d == stbrc_pkg::ST_WAKE);
    end
  end

  // Timer gating: outside stop everything runs, in stop only pin-clocked paths plus the wide timer on counter two output
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wide_timer_run <= 1'b1;
      counter_zero_run <= 1'b1;
      counter_one_run <= 1'b1;
      counter_two_run <= 1'b1;
      interval_timer_zero_run <= 1'b1;
    end
    else if (state_d == stbrc_pkg::ST_STOP)
    begin
      wide_timer_run <= tsel_q[stbrc_pkg::TSEL_WIDE_POS +: 2] == stbrc_pkg::WSEL_C2OUT ||
                        tsel_q[stbrc_pkg::TSEL_WIDE_POS +: 2] == stbrc_pkg::WSEL_PIN;
      counter_zero_run <= tsel_q[stbrc_pkg::TSEL_C0_POS +: 2] == stbrc_pkg::CSEL_PIN;
      counter_one_run <= tsel_q[stbrc_pkg::TSEL_C1_POS +: 2] == stbrc_pkg::CSEL_PIN;
      counter_two_run <= tsel_q[stbrc_pkg::TSEL_C2_POS +: 2] == stbrc_pkg::CSEL_PIN;
      interval_timer_zero_run <= tsel_q[stbrc_pkg::TSEL_H0_POS +: 2] == stbrc_pkg::HSEL_C0OUT &&
                                 tsel_q[stbrc_pkg::TSEL_C0_POS +: 2] == stbrc_pkg::CSEL_PIN &&
                                 counter_zero_running;
    end
    else
    begin
      wide_timer_run <= 1'b1;
      counter_zero_run <= 1'b1;
      counter_one_run <= 1'b1;
      counter_two_run <= 1'b1;
      interval_timer_zero_run <= 1'b1;
    end
  end

  // Register writes
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      osc_stabilization_select_q <= stbrc_pkg::OSC_STABILIZATION_SELECT_RST;
      tsel_q <= stbrc_pkg::TSEL_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == stbrc_pkg::REG_OSC_STABILIZATION_SELECT)
        osc_stabilization_select_q <= reg_wdata[2:0];
      if (reg_addr == stbrc_pkg::REG_TSEL)
        tsel_q <= reg_wdata[9:0];
    end
  end

  // Count of completed wakes from halt, readable for diagnosis
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      lat_cnt_q <= 16'h0000;
    else if (state_q == stbrc_pkg::ST_WAKE && cif.done)
      lat_cnt_q <= lat_cnt_q + 16'h0001;
  end

  // Read data valid the cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        stbrc_pkg::REG_OSC_STABILIZATION_SELECT: reg_rdata <= {13'h0000, osc_stabilization_select_q};
        stbrc_pkg::REG_TSEL: reg_rdata <= {6'h00, tsel_q};
        stbrc_pkg::REG_STAT: reg_rdata <= {12'h000, svc_q, 3'(state_q)};
        stbrc_pkg::REG_CNT: reg_rdata <= lat_cnt_q;
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // Assertions
  sequence s_halt_req;
    state_q == stbrc_pkg::ST_HALT && wake_req && cpu_clk_en;
  endsequence

  a_masked_holds_halt: assert property (@(posedge mclk) disable iff (sys_rst)
    state_q == stbrc_pkg::ST_HALT && !wake_req |=> state_q == stbrc_pkg::ST_HALT)
    else $error("masked request left halt");
  a_unmasked_wakes: assert property (@(posedge mclk) disable iff (sys_rst)
    state_q == stbrc_pkg::ST_HALT && wake_req |=> state_q == stbrc_pkg::ST_WAKE)
    else $error("unmasked request did not wake");
  a_service_latency: assert property (@(posedge mclk) disable iff (sys_rst)
    (s_halt_req and svc_now) ##1 cpu_clk_en [*7] |=> wake_service)
    else $error("service latency wrong");
  a_resume_latency: assert property (@(posedge mclk) disable iff (sys_rst)
    (s_halt_req and !svc_now) ##1 cpu_clk_en |=> wake_resume)
    else $error("resume latency wrong");
  a_reset_exits: assert property (@(posedge mclk)
    sys_rst |=> state_q == stbrc_pkg::ST_RUN && reset_vector_req)
    else $error("reset did not end standby");
  a_stop_needs_main: assert property (@(posedge mclk) disable iff (sys_rst)
    state_q == stbrc_pkg::ST_RUN && stop_exec && !cpu_on_main_clk |=> state_q != stbrc_pkg::ST_STOP)
    else $error("stop entered off main clock");
  a_stop_pending_halt: assert property (@(posedge mclk) disable iff (sys_rst)
    state_q == stbrc_pkg::ST_RUN && stop_exec && cpu_on_main_clk && wake_req |=> state_q == stbrc_pkg::ST_STAB)
    else $error("pending request entered stop");
  a_stop_clock_cut: assert property (@(posedge mclk) disable iff (sys_rst)
    state_q == stbrc_pkg::ST_STOP |-> !cpu_clk_gate && in_stop)
    else $error("cpu clock running in stop");
  a_c1_gated: assert property (@(posedge mclk) disable iff (sys_rst)
    state_q == stbrc_pkg::ST_STOP |-> counter_one_run == (tsel_q[stbrc_pkg::TSEL_C1_POS +: 2] == stbrc_pkg::CSEL_PIN))
    else $error("counter one gating wrong");
endmodule

// file: tb/stbrc_cpu_model.sv
// Behavioural CPU core and interrupt controller facing the standby controller
`timescale 1ns/1ps
module stbrc_cpu_model (
  input wire logic mclk,
  input wire logic slow,
  output logic cpu_clk_en,
  output logic halt_exec,
  output logic stop_exec,
  output logic irq_req,
  output logic [3:0] irq_flags
);
  initial
  begin
    cpu_clk_en = 1'b1;
    halt_exec = 1'b0;
    stop_exec = 1'b0;
    irq_req = 1'b0;
    irq_flags = 4'h8;
  end
  // Slow mode enables every other edge so latency counting is seen in CPU clocks
  always @(posedge mclk)
    cpu_clk_en <= slow ? ~cpu_clk_en : 1'b1;
  task automatic exec_instr(input logic is_stop);
    @(posedge mclk);
    halt_exec <= ~is_stop;
    stop_exec <= is_stop;
    @(posedge mclk);
    halt_exec <= 1'b0;
    stop_exec <= 1'b0;
  endtask
  // Flags are mask, priority, global accept, in-service
  task automatic set_irq(input logic [3:0] f);
    @(posedge mclk);
    irq_flags <= f;
    irq_req <= 1'b1;
  endtask
  // Request flag is cleared as the core takes or abandons it
  task automatic clr_irq();
    @(posedge mclk);
    irq_req <= 1'b0;
    irq_flags <= 4'h8;
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking testbench for the standby release controller
`timescale 1ns/1ps
module testbench;
  logic mclk;
  logic sys_rst;
  logic slow;
  logic on_main;
  logic c0_running;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic cpu_clk_en, halt_exec, stop_exec, irq_req, cpu_clk_gate, in_halt, in_stop;
  logic wake_service, wake_resume, reset_vector_req;
  logic [3:0] irq_flags;
  logic [4:0] run;
  int failures = 0;
  int samples_checked = 0;
  initial
  begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    slow = 1'b0;
    on_main = 1'b1;
    c0_running = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  always #20 mclk = ~mclk;
  stbrc_cpu_model cpu (.mclk(mclk), .slow(slow), .cpu_clk_en(cpu_clk_en), .halt_exec(halt_exec),
    .stop_exec(stop_exec), .irq_req(irq_req), .irq_flags(irq_flags));
  stbrc_top uut (.mclk(mclk), .sys_rst(sys_rst), .cpu_clk_en(cpu_clk_en), .cpu_on_main_clk(on_main),
    .halt_exec(halt_exec), .stop_exec(stop_exec), .irq_req(irq_req), .irq_mask_flag(irq_flags[3]),
    .irq_priority_flag(irq_flags[2]), .global_irq_accept(irq_flags[1]),
    .in_service_priority_state(irq_flags[0]), .counter_zero_running(c0_running),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_clk_gate(cpu_clk_gate), .in_halt(in_halt), .in_stop(in_stop),
    .wake_service(wake_service), .wake_resume(wake_resume), .reset_vector_req(reset_vector_req),
    .wide_timer_run(run[4]), .counter_zero_run(run[3]), .counter_one_run(run[2]),
    .counter_two_run(run[1]), .interval_timer_zero_run(run[0]));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_rng(input int n, input int lo, input int hi, input string msg);
    samples_checked++;
    if (n < lo || n > hi)
    begin
      failures++;
      $display("BAD %0t %s took %0d", $time, msg, n);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [15:0] exp, input string msg);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, msg);
  endtask
  task automatic do_reset(input int cycles);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (cycles) @(posedge mclk);
    #1 chk({in_halt, in_stop, reset_vector_req, cpu_clk_gate}, 16'h3, "reset state");
    sys_rst <= 1'b0;
  endtask
  // Counts edges after the request edge until a wake pulse or the cpu clock returns
  task automatic wait_wake(output int n);
    n = 0;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end while (wake_service !== 1'b1 && wake_resume !== 1'b1 && cpu_clk_gate !== 1'b1 && n < 1100);
  endtask
  task automatic t_regs();
    reg_read(4'h0, 16'h0005, "stab select reset");
    reg_read(4'h1, 16'h0000, "timer select reset");
    reg_read(4'h2, 16'h0000, "state reset");
    reg_write(4'h0, 16'h0000);
    reg_write(4'h2, 16'h0004);
    reg_read(4'h0, 16'h0000, "stab select write");
    reg_read(4'h2, 16'h0000, "read-only state");
    reg_read(4'hf, 16'h0000, "unmapped read");
    $display("regs done");
  endtask
  task automatic t_decode();
    logic [3:0] fl [6] = '{4'h0, 4'h2, 4'h5, 4'h4, 4'h7, 4'h6};
    logic [5:0] svc = 6'b010010;
    int n;
    for (int i = 0; i < 6; i++)
    begin
      cpu.exec_instr(1'b0);
      #1 chk(in_halt, 1'b1, "halt entry");
      cpu.set_irq(fl[i]);
      wait_wake(n);
      chk({wake_service, wake_resume}, {svc[5 - i], ~svc[5 - i]}, "wake kind");
      chk_rng(n, svc[5 - i] ? 8 : 2, svc[5 - i] ? 9 : 3, "wake latency");
      cpu.clr_irq();
      repeat (12) @(posedge mclk);
      #1 chk({in_halt, cpu_clk_gate}, 16'h1, "running after wake");
    end
    $display("decode done");
  endtask
  task automatic t_masked();
    cpu.exec_instr(1'b0);
    cpu.set_irq(4'ha);
    repeat (30) @(posedge mclk);
    #1 chk({in_halt, cpu_clk_gate}, 16'h2, "masked keeps halt");
    cpu.clr_irq();
    do_reset(1);
    @(posedge mclk);
    #1 chk(in_halt, 1'b0, "halt left by reset");
    reg_write(4'h0, 16'h0000);
    $display("masked done");
  endtask
  task automatic t_slow();
    int n;
    slow <= 1'b1;
    cpu.exec_instr(1'b0);
    cpu.set_irq(4'h2);
    wait_wake(n);
    chk(wake_service, 1'b1, "slow service");
    chk_rng(n, 15, 18, "latency in cpu clocks");
    cpu.clr_irq();
    slow <= 1'b0;
    repeat (4) @(posedge mclk);
    $display("slow done");
  endtask
  task automatic t_stop(input logic [15:0] sel, input logic c0r, input logic [4:0] exp, input logic pend);
    int n;
    reg_write(4'h1, sel);
    c0_running <= c0r;
    if (pend)
      cpu.set_irq(4'h0);
    cpu.exec_instr(1'b1);
    #1 chk(cpu_clk_gate, 1'b0, "cpu clock cut");
    if (pend)
      reg_read(4'h2, 16'h000b, "pending stop falls back");
    else
    begin
      chk(in_stop, 1'b1, "stop entry");
      chk(run, exp, "timers in stop");
      cpu.set_irq(4'h0);
    end
    wait_wake(n);
    chk_rng(n, pend ? 1020 : 1024, 1032, "stabilization wait");
    chk({in_stop, run}, 16'h1f, "timers after stop");
    cpu.clr_irq();
    $display("stop done");
  endtask
  task automatic t_stop_sub();
    on_main <= 1'b0;
    cpu.exec_instr(1'b1);
    repeat (3) @(posedge mclk);
    #1 chk({in_stop, cpu_clk_gate}, 16'h1, "stop refused off main");
    on_main <= 1'b1;
    $display("stop refuse done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    do_reset(10);
    t_regs();
    t_decode();
    t_masked();
    t_slow();
    t_stop_sub();
    t_stop(16'h03ce, 1'b1, 5'h1b, 1'b0);
    t_stop(16'h0333, 1'b1, 5'h14, 1'b0);
    t_stop(16'h030d, 1'b0, 5'h08, 1'b0);
    t_stop(16'h0000, 1'b1, 5'h00, 1'b1);
    conclude();
  end
  // Whole run needs about 4300 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
endmodule
